// ==== rtl/fcd_consts.svh ====
// Contract
// - Write deleted: opcode low bits 01001, nine bytes
// - Execution moves sector data, marked as deleted
// - Seven result bytes: three status, C H R N
// - Recalibrate steps to track 0, interrupt, no result
// - Sense interrupt: single opcode, status zero first
// - Second sense byte is present cylinder
// - Seek steps head to requested cylinder
// - Invalid opcode: standby, single status byte 80H
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH
`define FCD_REG_DATA     3'h0
`define FCD_REG_STATUS   3'h1
`define FCD_REG_IRQSTAT  3'h2
`define FCD_REG_IRQMASK  3'h3
`define FCD_REG_SECDATA  3'h4
`define FCD_REG_LAST     3'h4
`define FCD_OPC_WDEL     5'h09
`define FCD_OPC_RECAL    8'h07
`define FCD_OPC_SENSE    8'h08
`define FCD_OPC_SEEK     8'h0F
`define FCD_LEN_WDEL     4'h9
`define FCD_LEN_RECAL    4'h2
`define FCD_LEN_SENSE    4'h1
`define FCD_LEN_SEEK     4'h3
`define FCD_LEN_RES_WDEL 3'h7
`define FCD_LEN_RES_SNS  3'h2
`define FCD_LEN_RES_ONE  3'h1
`define FCD_B_OPC        0
`define FCD_B_DSEL       1
`define FCD_B_CYL        2
`define FCD_B_HEAD       3
`define FCD_B_SEC        4
`define FCD_B_SIZE       5
`define FCD_B_EOT        6
`define FCD_B_DTL        8
`define FCD_B_NCN        2
`define FCD_R_ST0        0
`define FCD_R_ST1        1
`define FCD_R_ST2        2
`define FCD_R_CYL        3
`define FCD_R_HEAD       4
`define FCD_R_SEC        5
`define FCD_R_SIZE       6
`define FCD_ST0_INVALID  8'h80
`define FCD_ST0_SEEKEND  8'h20
`define FCD_SEC_BASE     15'h0080
`define FCD_IRQ_SEEK     0
`define FCD_IRQ_RESULT   1
`define FCD_IRQ_INVALID  2
`define FCD_RESP_OKAY    2'h0
`define FCD_RESP_SLVERR  2'h2
`define FCD_CLK_NS       25
`define FCD_STEP_NS      3000
`define FCD_STEP_CYC     ((`FCD_STEP_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`endif

// ==== rtl/fcd_pkg.sv ====
package fcd_pkg;
  typedef enum logic [1:0] {
    FCD_S_CMD  = 2'b00,
    FCD_S_WDEL = 2'b01,
    FCD_S_STEP = 2'b10,
    FCD_S_RES  = 2'b11
  } fcd_state_type;
  typedef enum logic [2:0] {
    FCD_OP_WDEL    = 3'b000,
    FCD_OP_RECAL   = 3'b001,
    FCD_OP_SENSE   = 3'b010,
    FCD_OP_SEEK    = 3'b011,
    FCD_OP_INVALID = 3'b100
  } fcd_op_type;
  typedef struct packed {
    logic       head_side_select;
    logic [1:0] drivePick;
  } fcd_drvsel_type;
endpackage : fcd_pkg

// ==== rtl/fcd_step_unit.sv ====
`timescale 1ns/1ps
`include "fcd_consts.svh"
module fcd_step_unit (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic       recal,
  input  wire logic [7:0] curCyl,
  input  wire logic [7:0] target,
  input  wire logic       track0,
  output logic            stepPulse,
  output logic            stepDir,
  output logic            done,
  output logic [7:0]      endCyl
);
  import fcd_pkg::*;
  logic        active_r, active_nxt;
  logic        recal_r, recal_nxt;
  logic [7:0]  cyl_r, cyl_nxt;
  logic [7:0]  tgt_r, tgt_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic        pulse_r, pulse_nxt;
  logic        dir_r, dir_nxt;
  logic        done_r, done_nxt;

  always_comb
  begin
    active_nxt = active_r;
    recal_nxt  = recal_r;
    cyl_nxt    = cyl_r;
    tgt_nxt    = tgt_r;
    cnt_nxt    = cnt_r;
    pulse_nxt  = 1'b0;
    dir_nxt    = dir_r;
    done_nxt   = 1'b0;
    if (start)
    begin
      active_nxt = 1'b1;
      recal_nxt  = recal;
      cyl_nxt    = curCyl;
      tgt_nxt    = target;
      cnt_nxt    = 12'h000;
    end
    else if (active_r)
    begin
      if (cnt_r != 12'(`FCD_STEP_CYC - 1))
        cnt_nxt = cnt_r + 12'h001;
      else
      begin
        cnt_nxt = 12'h000;
        // Recal trusts track0 only, so an unknown start position is harmless
        if (recal_r)
        begin
          if (track0)
          begin
            active_nxt = 1'b0;
            done_nxt   = 1'b1;
            cyl_nxt    = 8'h00;
          end
          else
          begin
            pulse_nxt = 1'b1;
            dir_nxt   = 1'b0;
          end
        end
        else if (cyl_r == tgt_r)
        begin
          active_nxt = 1'b0;
          done_nxt   = 1'b1;
        end
        else
        begin
          pulse_nxt = 1'b1;
          dir_nxt   = (tgt_r > cyl_r);
          cyl_nxt   = (tgt_r > cyl_r) ? cyl_r + 8'h01 : cyl_r - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active_r <= 1'b0;
      recal_r  <= 1'b0;
      cyl_r    <= 8'h00;
      tgt_r    <= 8'h00;
      cnt_r    <= 12'h000;
      pulse_r  <= 1'b0;
      dir_r    <= 1'b0;
      done_r   <= 1'b0;
    end
    else if (ce)
    begin
      active_r <= active_nxt;
      recal_r  <= recal_nxt;
      cyl_r    <= cyl_nxt;
      tgt_r    <= tgt_nxt;
      cnt_r    <= cnt_nxt;
      pulse_r  <= pulse_nxt;
      dir_r    <= dir_nxt;
      done_r   <= done_nxt;
    end
  end

  assign stepPulse = pulse_r;
  assign stepDir   = dir_r;
  assign done      = done_r;
  assign endCyl    = cyl_r;
endmodule : fcd_step_unit

// ==== rtl/fcd_top.sv ====
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "fcd_consts.svh"
module fcd_top (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       irq,
  output fcd_pkg::fcd_drvsel_type    drvSel,
  output logic                       stepPulse,
  output logic                       stepDir,
  input  wire logic                  track0,
  output logic [7:0]                 diskByte,
  output logic                       diskByteValid,
  output logic                       deletedMark
);
  import fcd_pkg::*;

  function automatic fcd_op_type opKind(input logic [7:0] op);
    if (op[4:0] == `FCD_OPC_WDEL && op[5] == 1'b0)
      opKind = FCD_OP_WDEL;
    else if (op == `FCD_OPC_RECAL)
      opKind = FCD_OP_RECAL;
    else if (op == `FCD_OPC_SENSE)
      opKind = FCD_OP_SENSE;
    else if (op == `FCD_OPC_SEEK)
      opKind = FCD_OP_SEEK;
    else
      opKind = FCD_OP_INVALID;
  endfunction : opKind

  function automatic logic [3:0] cmdLen(input logic [7:0] op);
    case (opKind(op))
      FCD_OP_WDEL:  cmdLen = `FCD_LEN_WDEL;
      FCD_OP_RECAL: cmdLen = `FCD_LEN_RECAL;
      FCD_OP_SEEK:  cmdLen = `FCD_LEN_SEEK;
      default:      cmdLen = `FCD_LEN_SENSE;
    endcase
  endfunction : cmdLen

  // Bus slave
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wrFire, rdFire, dataWr, dataRd, secWr;
  logic [2:0]  wIdx, rIdx;
  logic [7:0]  wByte;

  assign wrFire = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rdFire = s_axi_arvalid && !rvalid_r;
  assign wIdx   = s_axi_awaddr[4:2];
  assign rIdx   = s_axi_araddr[4:2];
  assign wByte  = s_axi_wdata[7:0];
  assign s_axi_awready = wrFire;
  assign s_axi_wready  = wrFire;
  assign s_axi_arready = rdFire;

  // Core state
  fcd_state_type  state_r, state_nxt;
  logic [7:0]     cmdBuf_r [0:8];
  logic [7:0]     cmdBuf_nxt [0:8];
  logic [7:0]     resBuf_r [0:6];
  logic [7:0]     resBuf_nxt [0:6];
  logic [3:0]     cmdCnt_r, cmdCnt_nxt;
  logic [2:0]     resLen_r, resLen_nxt, resIdx_r, resIdx_nxt;
  logic [14:0]    byteCnt_r, byteCnt_nxt, secLen;
  logic [7:0]     sector_r, sector_nxt;
  fcd_drvsel_type drvSel_r, drvSel_nxt;
  logic           intPend_r, intPend_nxt;
  logic [7:0]     intSt0_r, intSt0_nxt;
  logic [1:0]     intDrv_r, intDrv_nxt;
  logic [7:0]     diskByte_r, diskByte_nxt;
  logic           diskValid_r, diskValid_nxt;
  logic [2:0]     irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt, ev;
  logic           stepStart, stepRecal, stepDone;
  logic [7:0]     stepTarget, endCyl;
  logic [7:0]     pcn_r [0:3];

  assign dataWr = wrFire && s_axi_wstrb[0] && wIdx == `FCD_REG_DATA && state_r == FCD_S_CMD;
  assign secWr  = wrFire && s_axi_wstrb[0] && wIdx == `FCD_REG_SECDATA
                  && state_r == FCD_S_WDEL;
  assign dataRd = rdFire && rIdx == `FCD_REG_DATA && state_r == FCD_S_RES;
  // Size code above 7 would overflow the counter, so only its low three bits are used
  assign secLen = (cmdBuf_r[`FCD_B_SIZE] == 8'h00) ? {7'h00, cmdBuf_r[`FCD_B_DTL]}
                  : `FCD_SEC_BASE << cmdBuf_r[`FCD_B_SIZE][2:0];

  always_comb
  begin
    state_nxt     = state_r;
    cmdBuf_nxt    = cmdBuf_r;
    resBuf_nxt    = resBuf_r;
    cmdCnt_nxt    = cmdCnt_r;
    resLen_nxt    = resLen_r;
    resIdx_nxt    = resIdx_r;
    byteCnt_nxt   = byteCnt_r;
    sector_nxt    = sector_r;
    drvSel_nxt    = drvSel_r;
    intPend_nxt   = intPend_r;
    intSt0_nxt    = intSt0_r;
    intDrv_nxt    = intDrv_r;
    diskByte_nxt  = diskByte_r;
    diskValid_nxt = 1'b0;
    stepStart     = 1'b0;
    stepRecal     = 1'b0;
    stepTarget    = cmdBuf_r[`FCD_B_NCN];
    ev            = 3'b000;
    case (state_r)
      FCD_S_CMD:
      begin
        if (dataWr)
        begin
          cmdBuf_nxt[cmdCnt_r] = wByte;
          cmdCnt_nxt = cmdCnt_r + 4'h1;
          if (cmdLen(cmdBuf_nxt[`FCD_B_OPC]) == cmdCnt_nxt)
          begin
            cmdCnt_nxt = 4'h0;
            drvSel_nxt = cmdBuf_nxt[`FCD_B_DSEL][2:0];
            resIdx_nxt = 3'h0;
            case (opKind(cmdBuf_nxt[`FCD_B_OPC]))
              FCD_OP_WDEL:
              begin
                state_nxt   = FCD_S_WDEL;
                sector_nxt  = cmdBuf_nxt[`FCD_B_SEC];
                byteCnt_nxt = 15'h0000;
              end
              FCD_OP_RECAL, FCD_OP_SEEK:
              begin
                state_nxt  = FCD_S_STEP;
                stepStart  = 1'b1;
                stepRecal  = (opKind(cmdBuf_nxt[`FCD_B_OPC]) == FCD_OP_RECAL);
                stepTarget = cmdBuf_nxt[`FCD_B_NCN];
                // Recal field has no side bit
                if (stepRecal)
                  drvSel_nxt.head_side_select = 1'b0;
              end
              FCD_OP_SENSE:
              begin
                state_nxt = FCD_S_RES;
                ev[`FCD_IRQ_RESULT] = 1'b1;
                if (intPend_r)
                begin
                  resBuf_nxt[`FCD_R_ST0] = intSt0_r;
                  resBuf_nxt[`FCD_R_ST1] = pcn_r[intDrv_r];
                  resLen_nxt  = `FCD_LEN_RES_SNS;
                  intPend_nxt = 1'b0;
                end
                else
                begin
                  // Nothing to report is answered like an invalid command
                  resBuf_nxt[`FCD_R_ST0] = `FCD_ST0_INVALID;
                  resLen_nxt = `FCD_LEN_RES_ONE;
                end
              end
              default:
              begin
                state_nxt = FCD_S_RES;
                resBuf_nxt[`FCD_R_ST0] = `FCD_ST0_INVALID;
                resLen_nxt = `FCD_LEN_RES_ONE;
                ev[`FCD_IRQ_INVALID] = 1'b1;
                ev[`FCD_IRQ_RESULT]  = 1'b1;
              end
            endcase
          end
        end
      end
      FCD_S_WDEL:
      begin
        if (secWr)
        begin
          diskByte_nxt  = wByte;
          diskValid_nxt = 1'b1;
          byteCnt_nxt   = byteCnt_r + 15'h0001;
          if (byteCnt_nxt == secLen)
          begin
            byteCnt_nxt = 15'h0000;
            if (sector_r == cmdBuf_r[`FCD_B_EOT])
            begin
              state_nxt  = FCD_S_RES;
              resLen_nxt = `FCD_LEN_RES_WDEL;
              resBuf_nxt[`FCD_R_ST0]  = {5'h00, drvSel_r};
              resBuf_nxt[`FCD_R_ST1]  = 8'h00;
              resBuf_nxt[`FCD_R_ST2]  = 8'h00;
              resBuf_nxt[`FCD_R_CYL]  = cmdBuf_r[`FCD_B_CYL];
              resBuf_nxt[`FCD_R_HEAD] = cmdBuf_r[`FCD_B_HEAD];
              resBuf_nxt[`FCD_R_SEC]  = sector_r;
              resBuf_nxt[`FCD_R_SIZE] = cmdBuf_r[`FCD_B_SIZE];
              ev[`FCD_IRQ_RESULT] = 1'b1;
            end
            else
              sector_nxt = sector_r + 8'h01;
          end
        end
      end
      FCD_S_STEP:
      begin
        if (stepDone)
        begin
          state_nxt   = FCD_S_CMD;
          intPend_nxt = 1'b1;
          intSt0_nxt  = `FCD_ST0_SEEKEND | {5'h00, drvSel_r};
          intDrv_nxt  = drvSel_r.drivePick;
          ev[`FCD_IRQ_SEEK] = 1'b1;
        end
      end
      FCD_S_RES:
      begin
        if (dataRd)
        begin
          resIdx_nxt = resIdx_r + 3'h1;
          if (resIdx_nxt == resLen_r)
            state_nxt = FCD_S_CMD;
        end
      end
      default: state_nxt = FCD_S_CMD;
    endcase
  end

  fcd_step_unit u_step (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .start     (stepStart),
    .recal     (stepRecal),
    .curCyl    (pcn_r[drvSel_nxt.drivePick]),
    .target    (stepTarget),
    .track0    (track0),
    .stepPulse (stepPulse),
    .stepDir   (stepDir),
    .done      (stepDone),
    .endCyl    (endCyl)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gPcn
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          pcn_r[g] <= 8'h00;
        else if (ce && stepDone && drvSel_r.drivePick == 2'(g))
          pcn_r[g] <= endCyl;
      end
    end
  endgenerate

  // Set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    irqStat_nxt = irqStat_r;
    irqMask_nxt = irqMask_r;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !s_axi_rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (wrFire)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = (wIdx > `FCD_REG_LAST) ? `FCD_RESP_SLVERR : `FCD_RESP_OKAY;
      if (wIdx == `FCD_REG_IRQSTAT && s_axi_wstrb[0])
        irqStat_nxt = irqStat_r & ~s_axi_wdata[2:0];
      if (wIdx == `FCD_REG_IRQMASK && s_axi_wstrb[0])
        irqMask_nxt = s_axi_wdata[2:0];
    end
    irqStat_nxt = irqStat_nxt | ev;
    if (rdFire)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `FCD_RESP_OKAY;
      case (rIdx)
        `FCD_REG_DATA:
          rdata_nxt = (state_r == FCD_S_RES) ? {24'h00_0000, resBuf_r[resIdx_r]} : 32'h0000_0000;
        `FCD_REG_STATUS:
          rdata_nxt = {16'h0000, pcn_r[drvSel_r.drivePick], 3'h0, intPend_r,
                       state_r == FCD_S_RES, state_r == FCD_S_STEP,
                       state_r == FCD_S_WDEL, state_r == FCD_S_CMD};
        `FCD_REG_IRQSTAT: rdata_nxt = {29'h0000_0000, irqStat_r};
        `FCD_REG_IRQMASK: rdata_nxt = {29'h0000_0000, irqMask_r};
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = (rIdx == `FCD_REG_SECDATA) ? `FCD_RESP_OKAY : `FCD_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r     <= FCD_S_CMD;
      cmdBuf_r    <= '{default: 8'h00};
      resBuf_r    <= '{default: 8'h00};
      cmdCnt_r    <= 4'h0;
      resLen_r    <= 3'h0;
      resIdx_r    <= 3'h0;
      byteCnt_r   <= 15'h0000;
      sector_r    <= 8'h00;
      drvSel_r    <= '0;
      intPend_r   <= 1'b0;
      intSt0_r    <= 8'h00;
      intDrv_r    <= 2'h0;
      diskByte_r  <= 8'h00;
      diskValid_r <= 1'b0;
      irqStat_r   <= 3'h0;
      irqMask_r   <= 3'h0;
      bvalid_r    <= 1'b0;
      bresp_r     <= 2'h0;
      rvalid_r    <= 1'b0;
      rresp_r     <= 2'h0;
      rdata_r     <= 32'h0000_0000;
    end
    else if (ce)
    begin
      state_r     <= state_nxt;
      cmdBuf_r    <= cmdBuf_nxt;
      resBuf_r    <= resBuf_nxt;
      cmdCnt_r    <= cmdCnt_nxt;
      resLen_r    <= resLen_nxt;
      resIdx_r    <= resIdx_nxt;
      byteCnt_r   <= byteCnt_nxt;
      sector_r    <= sector_nxt;
      drvSel_r    <= drvSel_nxt;
      intPend_r   <= intPend_nxt;
      intSt0_r    <= intSt0_nxt;
      intDrv_r    <= intDrv_nxt;
      diskByte_r  <= diskByte_nxt;
      diskValid_r <= diskValid_nxt;
      irqStat_r   <= irqStat_nxt;
      irqMask_r   <= irqMask_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign irq           = |(irqStat_r & irqMask_r);
  assign drvSel        = drvSel_r;
  assign diskByte      = diskByte_r;
  assign diskByteValid = diskValid_r;
  // Held through the last byte's pulse, which lands after the state has moved on
  assign deletedMark   = (state_r == FCD_S_WDEL) || diskValid_r;
endmodule : fcd_top

// ==== testbench/fcd_drive_model.sv ====
`timescale 1ns/1ps
module fcd_drive_model #(
  parameter int START_CYL = 3
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stepPulse,
  input  wire logic       stepDir,
  output logic            track0,
  output logic [7:0]      cyl
);
  // One head shared by all drive selects; enough for serial seeks
  always_ff @(posedge clk or posedge rst)
    if (rst)
      cyl <= START_CYL[7:0];
    else if (stepPulse && stepDir)
      cyl <= cyl + 8'h01;
    else if (stepPulse && cyl != 8'h00)
      cyl <= cyl - 8'h01;
  assign track0 = (cyl == 8'h00);
endmodule : fcd_drive_model

// ==== testbench/fcd_properties.sv ====
`timescale 1ns/1ps
module fcd_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        stepPulse,
  input wire logic        stepDir,
  input wire logic        track0,
  input wire logic        diskByteValid,
  input wire logic        deletedMark
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_PAIR_READY: assert property (s_axi_awready == s_axi_wready)
    else $error("write ready halves differ");
  AST_WRITE_ANSWER: assert property (ce && s_axi_awready |=> s_axi_bvalid)
    else $error("write taken without response");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_READ_ANSWER: assert property (ce && s_axi_arready |=>
    s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("read answer late or upper bits set");
  AST_BYTE_MARKED: assert property (diskByteValid |-> deletedMark)
    else $error("sector byte outside deleted write");
  AST_BYTE_PULSE: assert property (diskByteValid |=> !diskByteValid)
    else $error("sector byte pulse too long");
  AST_STEP_SPACING: assert property (stepPulse |=> !stepPulse [*8])
    else $error("step pulses too close");
  // Outward step only while the head is off track 0
  AST_RECAL_OUT: assert property (stepPulse && !stepDir |-> !$past(track0))
    else $error("outward step at track 0");

  COV_BYTE: cover property (diskByteValid);
  COV_OUT:  cover property (stepPulse && !stepDir);
  COV_IN:   cover property (stepPulse && stepDir);
endmodule : fcd_properties

// ==== testbench/floppy_command_phase_decoder_bench.sv ====
`timescale 1ns/1ps
`define BENCH_CHK(a, b) \
  begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module floppy_command_phase_decoder_bench;
  import fcd_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic           ce = 1'b1;
  logic [7:0]     s_axi_awaddr = 8'h00;
  logic           s_axi_awvalid = 1'b0;
  logic           s_axi_awready;
  logic [31:0]    s_axi_wdata = 32'h0000_0000;
  logic [3:0]     s_axi_wstrb = 4'hF;
  logic           s_axi_wvalid = 1'b0;
  logic [1:0]     s_axi_bresp;
  logic           s_axi_bvalid;
  logic           s_axi_bready = 1'b0;
  logic [7:0]     s_axi_araddr = 8'h00;
  logic           s_axi_arvalid = 1'b0;
  logic           s_axi_arready;
  logic [31:0]    s_axi_rdata;
  logic [1:0]     s_axi_rresp;
  logic           s_axi_rvalid;
  logic           s_axi_rready = 1'b0;
  logic           irq;
  fcd_drvsel_type drvSel;
  logic           stepPulse;
  logic           stepDir;
  logic           track0;
  logic [7:0]     diskByte;
  logic           diskByteValid;
  logic           deletedMark;
  logic [7:0]     cyl;
  logic [31:0]    d;
  logic [1:0]     lastResp;
  logic [7:0]     gotBytes[$];
  int             n_fail = 0;
  int             samples_checked = 0;
  int             markBad = 0;
  logic [7:0]     wdelCmd[9] = '{8'hC9, 8'h03, 8'h05, 8'h00, 8'h01, 8'h00, 8'h02, 8'h1B, 8'h03};
  logic [7:0]     wdelRes[7] = '{8'h03, 8'h00, 8'h00, 8'h05, 8'h00, 8'h02, 8'h00};
  logic [7:0]     seekTab[6] = '{8'h05, 8'h05, 8'h05, 8'h02, 8'h01, 8'h02};

  always #12.5 clk = ~clk;

  fcd_top i_dut (
    .clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq), .drvSel(drvSel),
    .stepPulse(stepPulse), .stepDir(stepDir), .track0(track0), .diskByte(diskByte),
    .diskByteValid(diskByteValid), .deletedMark(deletedMark)
  );

  fcd_drive_model #(.START_CYL(3)) i_drive (
    .clk(clk), .rst(rst), .stepPulse(stepPulse), .stepDir(stepDir),
    .track0(track0), .cyl(cyl)
  );

  always @(negedge clk)
    if (diskByteValid === 1'b1)
    begin
      gotBytes.push_back(diskByte);
      if (deletedMark !== 1'b1)
        markBad++;
    end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Levels sampled at the falling edge stay put until the next rising edge
  task automatic waitFor(input int k);
    for (int i = 0; i < 2000; i++)
    begin
      @(negedge clk);
      if ((k == 0 && s_axi_awready === 1'b1) || (k == 1 && s_axi_bvalid === 1'b1) ||
          (k == 2 && s_axi_arready === 1'b1) || (k == 3 && s_axi_rvalid === 1'b1) ||
          (k == 4 && irq === 1'b1))
        return;
    end
    n_fail++;
    $display("ERROR %0t wait %0d timed out", $time, k);
    end_of_test();
  endtask : waitFor

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    waitFor(0);
    @(posedge clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    waitFor(1);
    lastResp = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    waitFor(2);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    waitFor(3);
    v = s_axi_rdata;
    lastResp = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic sense(input logic [7:0] st0, input logic [7:0] present_cylinder);
    wr(8'h00, 8'h08);
    rd(8'h00, d);
    `BENCH_CHK(d, {24'h00_0000, st0})
    rd(8'h00, d);
    `BENCH_CHK(d, {24'h00_0000, present_cylinder})
    wr(8'h08, 8'h07);
  endtask : sense

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'h0C, 8'h07);
    `BENCH_CHK(lastResp, 2'h0)
    wr(8'h00, 8'h10);
    rd(8'h00, d);
    `BENCH_CHK(d, 32'h0000_0080)
    rd(8'h08, d);
    `BENCH_CHK(d, 32'h0000_0006)
    `BENCH_CHK(irq, 1'b1)
    wr(8'h08, 8'h07);
    rd(8'h00, d);
    `BENCH_CHK(d, 32'h0000_0000)
    `BENCH_CHK(irq, 1'b0)
    wr(8'h00, 8'h08);
    rd(8'h00, d);
    `BENCH_CHK(d, 32'h0000_0080)
    wr(8'h08, 8'h07);
    rd(8'h18, d);
    `BENCH_CHK(lastResp, 2'h2)
    wr(8'h18, 8'h00);
    `BENCH_CHK(lastResp, 2'h2)
    wr(8'h00, 8'h07);
    wr(8'h00, 8'h02);
    // Enable low must freeze the step timer, so no step reaches the drive
    ce <= 1'b0;
    repeat (300) @(posedge clk);
    `BENCH_CHK(cyl, 8'h03)
    ce <= 1'b1;
    waitFor(4);
    @(posedge clk);
    `BENCH_CHK(cyl, 8'h00)
    `BENCH_CHK(drvSel.drivePick, 2'd2)
    rd(8'h08, d);
    `BENCH_CHK(d, 32'h0000_0001)
    rd(8'h00, d);
    `BENCH_CHK(d, 32'h0000_0000)
    wr(8'h08, 8'h07);
    sense(8'h22, 8'h00);
    // Inward, outward, then a seek that is already there
    for (int s = 0; s < 6; s += 2)
    begin
      wr(8'h00, 8'h0F);
      wr(8'h00, seekTab[s]);
      wr(8'h00, seekTab[s+1]);
      waitFor(4);
      @(posedge clk);
      `BENCH_CHK(cyl, seekTab[s+1])
      `BENCH_CHK(drvSel, seekTab[s][2:0])
      wr(8'h08, 8'h07);
      rd(8'h04, d);
      `BENCH_CHK(d[15:8], seekTab[s+1])
      sense(8'h20 | seekTab[s], seekTab[s+1]);
    end
    foreach (wdelCmd[i])
      wr(8'h00, wdelCmd[i]);
    rd(8'h04, d);
    `BENCH_CHK(d[1], 1'b1)
    `BENCH_CHK(drvSel.drivePick, 2'd3)
    for (int i = 0; i < 6; i++)
      wr(8'h10, 8'hA0 + 8'(i));
    `BENCH_CHK(gotBytes.size(), 6)
    foreach (gotBytes[i])
      `BENCH_CHK(gotBytes[i], 8'hA0 + 8'(i))
    `BENCH_CHK(markBad, 0)
    rd(8'h08, d);
    `BENCH_CHK(d[1], 1'b1)
    foreach (wdelRes[i])
    begin
      rd(8'h00, d);
      `BENCH_CHK(d, {24'h00_0000, wdelRes[i]})
    end
    rd(8'h00, d);
    `BENCH_CHK(d, 32'h0000_0000)
    end_of_test();
  end
endmodule : floppy_command_phase_decoder_bench

bind fcd_top fcd_properties i_props (
  .clk(clk), .rst(rst), .ce(ce), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .stepPulse(stepPulse), .stepDir(stepDir), .track0(track0),
  .diskByteValid(diskByteValid), .deletedMark(deletedMark)
);
